// ---- rtl/flic_ctrl.sv ----
// How it works
// (R1) Slot n vectors to 0003h plus eight times n; slot 6 is reserved.
// (R2) A slot requests when any flag is set, its enable is 1, global is 1.
// (R3) Global enable 0 blocks every slot; 1 lets each enable decide.
// (R4) Software writes to request flags act like hardware set or clear, except external flags in level mode.
// (R5) Equal-level requests are served lowest slot first.
// (R6) Each external pin is level or edge sensed by its own type bit.
// (R7) Vectoring clears an external flag only in edge mode; level follows the pin.
// (R8) Timer 0 and 1 overflow flags clear automatically when vectored.
// (R9) Serial request is receive-done OR transmit-done; software clears both.
// (R10) Timer 2 request ORs overflow, external and split low-overflow flags.
// (R11) SPI done flag raises the SPI request and stays set on vectoring.
// (R12) ADC request ORs conversion-done, window and sampling flags.
// (R13) Counter array request ORs base overflow and four module flags.
// (R14) System request ORs nine system flags, plus tx-done when routed.
// (R15) System flags are set by their sources and never cleared on vectoring.
// (R16) Keypad, two-wire and comparator flags each request and stay set.
// (R17) External flags sit at timer-control bits 1 and 3, timer flags 5, 7.
// (R18) Enables map to primary bits 0-5 and extended bits 0-3, 5-7.
// (R19) Each slot has a high and a low priority bit.
// (R20) Pair 11 is top level; running handlers block equal or lower levels.
// (R21) Flags sampled each clock, polled next; call only at instruction end.
// (R22) After a return or enable/priority write one more instruction runs first; the code lets two more run before the call.
// (R23) Polarity 0 selects low or falling; polarity 1 selects high or rising.
// (R24) Vector and strobe go to the core; edge-mode external and timer 0/1 flags clear on its acknowledge.
`timescale 1ns/1ps

module flic_ctrl
    import flic_pkg::*;
(
    // Clock and reset
    input logic clock_i,
    input logic rstn_i,
    // External pins and timer events
    input logic ext_pin0_input_i,
    input logic ext_pin1_input_i,
    input logic timer0_overflow_i,
    input logic timer1_overflow_i,
    // Flags owned by the peripheral blocks
    input flic_src_flags_t src_flags_i,
    // Configuration registers held by the core
    input flic_cfg_t cfg_i,
    // Software write of the timer control register flags
    input logic timer_control_reg_we_i,
    input logic [7:0] timer_control_reg_wdata_i,
    // Instruction sequencer
    input logic insn_last_i,
    input logic insn_block_i,
    input logic reti_i,
    input logic vector_ack_i,
    // Vectored call request
    output logic vector_req_o,
    output logic [15:0] vector_addr_o,
    // Status
    output logic [7:0] timer_control_reg_o,
    output logic [NUM_LEVELS-1:0] active_levels_o,
    output logic [NUM_SLOTS-1:0] pending_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Spreads an 8-bit primary and an 8-bit extended register over the slots.
    function automatic logic [NUM_SLOTS-1:0] slot_bits(input logic [7:0] prim, input logic [7:0] ext);
        logic [NUM_SLOTS-1:0] r;
        r = '0;
        r[5:0] = prim[5:0];
        r[10:7] = ext[3:0];
        r[13:11] = ext[7:5];
        return r;
    endfunction : slot_bits

    // ------------------------------------------------------------------
    // External pin detection
    // ------------------------------------------------------------------
    logic ext0_active;
    logic ext0_edge;
    logic ext1_active;
    logic ext1_edge;

    flic_ext_pin u_ext0 (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .pin_i(ext_pin0_input_i),
        .polarity_i(cfg_i.ext_pin0_polarity),
        .active_o(ext0_active),
        .edge_o(ext0_edge)
    );

    flic_ext_pin u_ext1 (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .pin_i(ext_pin1_input_i),
        .polarity_i(cfg_i.ext_pin1_polarity),
        .active_o(ext1_active),
        .edge_o(ext1_edge)
    );

    // ------------------------------------------------------------------
    // Timer control register flags
    // ------------------------------------------------------------------
    flic_state_t state_q;
    logic [3:0] win_slot_q;
    logic [1:0] win_lvl_q;
    logic call_ack;
    logic ext_pin0_request_q;
    logic ext_pin1_request_q;
    logic timer0_overflow_flag_q;
    logic timer1_overflow_flag_q;

    assign call_ack = vector_ack_i && (state_q == FLIC_CALL);

    // Hardware set always wins over a software or acknowledge clear.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_pin0_request_q <= TIMER_CONTROL_REG_RESET[TIMER_CONTROL_REG_EXT0_BIT];
            ext_pin1_request_q <= TIMER_CONTROL_REG_RESET[TIMER_CONTROL_REG_EXT1_BIT];
        end else begin
            // Level mode tracks the pin, so a software write has no effect there.
            if (!cfg_i.ext_pin0_type) begin // R6
                ext_pin0_request_q <= ext0_active; // R7
            end else if (ext0_edge) begin
                ext_pin0_request_q <= 1'b1;
            end else if (timer_control_reg_we_i) begin
                ext_pin0_request_q <= timer_control_reg_wdata_i[TIMER_CONTROL_REG_EXT0_BIT]; // R4 R17
            end else if (call_ack && win_slot_q == SLOT_EXT0) begin
                ext_pin0_request_q <= 1'b0; // R7 R24
            end
            if (!cfg_i.ext_pin1_type) begin // R6
                ext_pin1_request_q <= ext1_active; // R7
            end else if (ext1_edge) begin
                ext_pin1_request_q <= 1'b1;
            end else if (timer_control_reg_we_i) begin
                ext_pin1_request_q <= timer_control_reg_wdata_i[TIMER_CONTROL_REG_EXT1_BIT]; // R4 R17
            end else if (call_ack && win_slot_q == SLOT_EXT1) begin
                ext_pin1_request_q <= 1'b0; // R7 R24
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            timer0_overflow_flag_q <= TIMER_CONTROL_REG_RESET[TIMER_CONTROL_REG_TMR0_BIT];
            timer1_overflow_flag_q <= TIMER_CONTROL_REG_RESET[TIMER_CONTROL_REG_TMR1_BIT];
        end else begin
            if (timer0_overflow_i) begin
                timer0_overflow_flag_q <= 1'b1;
            end else if (timer_control_reg_we_i) begin
                timer0_overflow_flag_q <= timer_control_reg_wdata_i[TIMER_CONTROL_REG_TMR0_BIT]; // R4 R17
            end else if (call_ack && win_slot_q == SLOT_TMR0) begin
                timer0_overflow_flag_q <= 1'b0; // R8 R24
            end
            if (timer1_overflow_i) begin
                timer1_overflow_flag_q <= 1'b1;
            end else if (timer_control_reg_we_i) begin
                timer1_overflow_flag_q <= timer_control_reg_wdata_i[TIMER_CONTROL_REG_TMR1_BIT]; // R4 R17
            end else if (call_ack && win_slot_q == SLOT_TMR1) begin
                timer1_overflow_flag_q <= 1'b0; // R8 R24
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_reg_o <= TIMER_CONTROL_REG_RESET;
        end else begin
            timer_control_reg_o <= TIMER_CONTROL_REG_RESET;
            timer_control_reg_o[TIMER_CONTROL_REG_EXT0_BIT] <= ext_pin0_request_q; // R17
            timer_control_reg_o[TIMER_CONTROL_REG_EXT1_BIT] <= ext_pin1_request_q;
            timer_control_reg_o[TIMER_CONTROL_REG_TMR0_BIT] <= timer0_overflow_flag_q;
            timer_control_reg_o[TIMER_CONTROL_REG_TMR1_BIT] <= timer1_overflow_flag_q;
        end
    end

    // ------------------------------------------------------------------
    // Request gathering and sampling
    // ------------------------------------------------------------------
    logic [NUM_SLOTS-1:0] flag_vec;
    logic [NUM_SLOTS-1:0] en_vec;
    logic [NUM_SLOTS-1:0] req_vec;
    logic [NUM_SLOTS-1:0] samp_q;
    logic global_en;

    // The peripheral flags stay set until their owners clear them.
    always_comb begin
        flag_vec = '0;
        flag_vec[SLOT_EXT0] = ext_pin0_request_q;
        flag_vec[SLOT_TMR0] = timer0_overflow_flag_q;
        flag_vec[SLOT_EXT1] = ext_pin1_request_q;
        flag_vec[SLOT_TMR1] = timer1_overflow_flag_q;
        flag_vec[SLOT_SERIAL] = src_flags_i.serial_rx_done | src_flags_i.serial_tx_done; // R9
        flag_vec[SLOT_TMR2] = src_flags_i.timer2_overflow_flag | src_flags_i.timer2_external_flag
            | (src_flags_i.timer2_split & src_flags_i.timer2_low_overflow_flag); // R10
        flag_vec[SLOT_SPI] = src_flags_i.spi_transfer_done; // R11
        flag_vec[SLOT_ADC] = src_flags_i.adc_conversion_done | src_flags_i.adc_window_flag
            | src_flags_i.adc_sampling_flag; // R12
        flag_vec[SLOT_ARRAY] = src_flags_i.array_base_overflow | (|src_flags_i.array_module_flags); // R13
        flag_vec[SLOT_SYSTEM] = src_flags_i.rtc_overflow_flag | src_flags_i.brownout_a_flag
            | src_flags_i.brownout_b_flag | src_flags_i.watchdog_overflow_flag
            | src_flags_i.stack_warning_flag | src_flags_i.clock_fail_flag
            | src_flags_i.nonvolatile_write_flag | src_flags_i.bus_start_detect_flag
            | src_flags_i.bus_stop_detect_flag
            | (src_flags_i.tx_done_to_system_vector & src_flags_i.serial_tx_done); // R14 R15
        flag_vec[SLOT_KEYPAD] = src_flags_i.keypad_match_flag; // R16
        flag_vec[SLOT_TWO_WIRE] = src_flags_i.two_wire_state_flag; // R16
        flag_vec[SLOT_COMPARATOR] = src_flags_i.comparator_edge_flag; // R16
    end

    assign global_en = cfg_i.primary_enable_reg[GLOBAL_ENABLE_BIT];
    assign en_vec = slot_bits(cfg_i.primary_enable_reg, cfg_i.extended_enable_reg); // R18
    assign req_vec = global_en ? (flag_vec & en_vec) : '0; // R2 R3

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            samp_q <= '0;
        end else begin
            samp_q <= req_vec; // R21
        end
    end

    // ------------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------------
    logic [NUM_SLOTS-1:0] prio_h;
    logic [NUM_SLOTS-1:0] prio_l;
    logic [NUM_LEVELS-1:0] act_q;
    logic win_valid;
    logic [3:0] win_slot;
    logic [1:0] win_lvl;
    logic act_any;
    logic [1:0] act_top;

    assign prio_h = slot_bits(cfg_i.priority_high_reg, cfg_i.ext_priority_high_reg); // R19
    assign prio_l = slot_bits(cfg_i.priority_low_reg, cfg_i.ext_priority_low_reg); // R19

    // Outer loop climbs the levels, inner loop walks slots downward, so the
    // last hit is the highest level and, within it, the lowest slot.
    always_comb begin
        win_valid = 1'b0;
        win_slot = '0;
        win_lvl = '0;
        for (int lv = 0; lv < NUM_LEVELS; lv++) begin
            for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
                if (samp_q[s] && {prio_h[s], prio_l[s]} == lv[1:0]) begin // R20
                    win_valid = 1'b1;
                    win_slot = s[3:0]; // R5
                    win_lvl = lv[1:0];
                end
            end
        end
    end

    always_comb begin
        act_any = 1'b0;
        act_top = '0;
        for (int lv = 0; lv < NUM_LEVELS; lv++) begin
            if (act_q[lv]) begin
                act_any = 1'b1;
                act_top = lv[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Call sequencing
    // ------------------------------------------------------------------
    logic hold_q;
    logic may_call;

    // A blocking instruction leaves a hold that lasts through the next one.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else if (insn_last_i) begin
            hold_q <= insn_block_i; // R22
        end
    end

    assign may_call = win_valid && insn_last_i && !insn_block_i && !hold_q
        && (!act_any || win_lvl > act_top); // R20 R21 R22

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FLIC_IDLE;
            win_slot_q <= '0;
            win_lvl_q <= '0;
        end else begin
            unique case (state_q)
                FLIC_IDLE: begin
                    if (may_call) begin
                        state_q <= FLIC_CALL;
                        win_slot_q <= win_slot;
                        win_lvl_q <= win_lvl;
                    end
                end
                FLIC_CALL: begin
                    if (vector_ack_i) begin
                        state_q <= FLIC_IDLE; // R24
                    end
                end
                default: begin
                    state_q <= FLIC_IDLE;
                end
            endcase
        end
    end

    // A return drops the highest level in progress; an acknowledge opens one.
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= '0;
        end else begin
            for (int lv = 0; lv < NUM_LEVELS; lv++) begin
                if (call_ack && win_lvl_q == lv[1:0]) begin
                    act_q[lv] <= 1'b1; // R20
                end else if (reti_i && act_any && act_top == lv[1:0]) begin
                    act_q[lv] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            vector_req_o <= 1'b0;
            vector_addr_o <= VEC_BASE;
            active_levels_o <= '0;
            pending_o <= '0;
        end else begin
            vector_req_o <= (state_q == FLIC_IDLE) ? may_call : !vector_ack_i; // R24
            if (state_q == FLIC_IDLE && may_call) begin
                vector_addr_o <= VEC_BASE + {9'h000, win_slot, 3'h0}; // R1
            end
            active_levels_o <= act_q;
            pending_o <= samp_q;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_vec_addr;
        @(posedge clock_i) disable iff (!rst_n)
        vector_req_o |-> (vector_addr_o[2:0] == 3'h3 && vector_addr_o <= 16'h006b && vector_addr_o != 16'h0033);
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address off grid"); // R1

    property p_req_enabled;
        @(posedge clock_i) disable iff (!rst_n)
        (samp_q != '0) |-> ($past(global_en) && (samp_q & ~$past(en_vec)) == '0);
    endproperty
    a_req_enabled: assert property (p_req_enabled) else $error("request taken while disabled"); // R2 R3

    property p_call_at_end;
        @(posedge clock_i) disable iff (!rst_n)
        $rose(vector_req_o) |-> $past(insn_last_i) && $past(samp_q) != '0;
    endproperty
    a_call_at_end: assert property (p_call_at_end) else $error("call outside instruction end"); // R21

    property p_call_level;
        @(posedge clock_i) disable iff (!rst_n)
        $rose(vector_req_o) |-> (!$past(act_any) || win_lvl_q > $past(act_top));
    endproperty
    a_call_level: assert property (p_call_level) else $error("call did not outrank running level"); // R20

    property p_hold_after_block;
        @(posedge clock_i) disable iff (!rst_n)
        (insn_last_i && insn_block_i) |=> !$rose(vector_req_o);
    endproperty
    a_hold_after_block: assert property (p_hold_after_block) else $error("call right after blocking insn"); // R22

    property p_tmr0_clear;
        @(posedge clock_i) disable iff (!rst_n)
        (call_ack && win_slot_q == SLOT_TMR0 && !timer0_overflow_i && !timer_control_reg_we_i) |=> !timer0_overflow_flag_q;
    endproperty
    a_tmr0_clear: assert property (p_tmr0_clear) else $error("timer 0 flag survived vectoring"); // R8

    property p_level_follows;
        @(posedge clock_i) disable iff (!rst_n)
        !cfg_i.ext_pin0_type |=> ext_pin0_request_q == $past(ext0_active);
    endproperty
    a_level_follows: assert property (p_level_follows) else $error("level flag not tracking pin"); // R7

    property p_req_stable;
        @(posedge clock_i) disable iff (!rst_n)
        (vector_req_o && !vector_ack_i) |=> vector_req_o && $stable(vector_addr_o);
    endproperty
    a_req_stable: assert property (p_req_stable) else $error("request dropped before acknowledge"); // R24

endmodule : flic_ctrl

// ---- rtl/flic_pkg.sv ----
package flic_pkg;

    // ------------------------------------------------------------------
    // Slots, vectors and register bit positions
    // ------------------------------------------------------------------
    localparam int NUM_SLOTS = 14;
    localparam int NUM_LEVELS = 4;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;
    localparam logic [3:0] SLOT_EXT0 = 4'h0;
    localparam logic [3:0] SLOT_TMR0 = 4'h1;
    localparam logic [3:0] SLOT_EXT1 = 4'h2;
    localparam logic [3:0] SLOT_TMR1 = 4'h3;
    localparam logic [3:0] SLOT_SERIAL = 4'h4;
    localparam logic [3:0] SLOT_TMR2 = 4'h5;
    localparam logic [3:0] SLOT_RESERVED = 4'h6;
    localparam logic [3:0] SLOT_SPI = 4'h7;
    localparam logic [3:0] SLOT_ADC = 4'h8;
    localparam logic [3:0] SLOT_ARRAY = 4'h9;
    localparam logic [3:0] SLOT_SYSTEM = 4'ha;
    localparam logic [3:0] SLOT_KEYPAD = 4'hb;
    localparam logic [3:0] SLOT_TWO_WIRE = 4'hc;
    localparam logic [3:0] SLOT_COMPARATOR = 4'hd;

    localparam int TIMER_CONTROL_REG_EXT0_BIT = 1;
    localparam int TIMER_CONTROL_REG_EXT1_BIT = 3;
    localparam int TIMER_CONTROL_REG_TMR0_BIT = 5;
    localparam int TIMER_CONTROL_REG_TMR1_BIT = 7;
    localparam logic [7:0] TIMER_CONTROL_REG_RESET = 8'h00;

    // Extended register bit 4 is unused; slots 7..13 map to bits 0,1,2,3,5,6,7.
    localparam int EXT_RESERVED_BIT = 4;
    localparam int GLOBAL_ENABLE_BIT = 7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic serial_rx_done;
        logic serial_tx_done;
        logic timer2_overflow_flag;
        logic timer2_external_flag;
        logic timer2_low_overflow_flag;
        logic timer2_split;
        logic spi_transfer_done;
        logic adc_conversion_done;
        logic adc_window_flag;
        logic adc_sampling_flag;
        logic array_base_overflow;
        logic [3:0] array_module_flags;
        logic rtc_overflow_flag;
        logic brownout_a_flag;
        logic brownout_b_flag;
        logic watchdog_overflow_flag;
        logic stack_warning_flag;
        logic clock_fail_flag;
        logic nonvolatile_write_flag;
        logic bus_start_detect_flag;
        logic bus_stop_detect_flag;
        logic tx_done_to_system_vector;
        logic keypad_match_flag;
        logic two_wire_state_flag;
        logic comparator_edge_flag;
    } flic_src_flags_t;

    typedef struct packed {
        logic [7:0] primary_enable_reg;
        logic [7:0] extended_enable_reg;
        logic [7:0] priority_high_reg;
        logic [7:0] priority_low_reg;
        logic [7:0] ext_priority_high_reg;
        logic [7:0] ext_priority_low_reg;
        logic ext_pin0_type;
        logic ext_pin1_type;
        logic ext_pin0_polarity;
        logic ext_pin1_polarity;
    } flic_cfg_t;

    typedef enum logic [1:0] {
        FLIC_IDLE = 2'b01,
        FLIC_CALL = 2'b10
    } flic_state_t;

endpackage : flic_pkg

// ---- rtl/flic_ext_pin.sv ----
`timescale 1ns/1ps

module flic_ext_pin
    import flic_pkg::*;
(
    // Clock and reset
    input logic clock_i,
    input logic rst_n_i,
    // Pin and sense selection
    input logic pin_i,
    input logic polarity_i,
    // Detected conditions
    output logic active_o,
    output logic edge_o
);

    logic prev_q;
    logic primed_q;
    logic active_q;
    logic edge_q;
    logic now_active;

    // Polarity 0 means low level or falling edge, 1 means high or rising.
    assign now_active = (pin_i == polarity_i); // R23

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
            primed_q <= 1'b0;
            active_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            prev_q <= pin_i;
            primed_q <= 1'b1;
            active_q <= now_active;
            // The reset value of the previous sample is not the pin's level, so no edge is
            // taken until one real sample has been stored; a high pin in rising mode would
            // otherwise raise a false request right after reset.
            edge_q <= primed_q && now_active && (prev_q != polarity_i); // R23
        end
    end

    assign active_o = active_q;
    assign edge_o = edge_q;

endmodule : flic_ext_pin

// ---- bench/flic_core_model.sv ----
`timescale 1ns/1ps

module flic_core_model (
    // Clock and reset
    input logic clock_i,
    input logic rstn_i,
    // Sequencer side of the controller
    input logic vector_req_i,
    output logic vector_ack_o,
    output logic insn_last_o,
    output logic insn_block_o,
    output logic reti_o
);
    logic [3:0] cnt_q;
    logic busy_q;
    logic odd_q;

    // Two-cycle instructions; a return is a blocking instruction ending on its last cycle.
    assign insn_last_o = odd_q;
    assign insn_block_o = reti_o;

    // The call is taken two cycles late, and a short handler then returns so the level drops.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vector_ack_o <= 1'b0;
            reti_o <= 1'b0;
            busy_q <= 1'b0;
            odd_q <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            vector_ack_o <= 1'b0;
            reti_o <= 1'b0;
            odd_q <= ~odd_q;
            cnt_q <= cnt_q + 4'h1;
            if (busy_q && cnt_q >= 4'h4 && !odd_q) begin
                reti_o <= 1'b1;
                busy_q <= 1'b0;
                cnt_q <= 4'h0;
            end else if (!busy_q && !vector_req_i) begin
                cnt_q <= 4'h0;
            end else if (!busy_q && !vector_ack_o && cnt_q == 4'h2) begin
                vector_ack_o <= 1'b1;
                busy_q <= 1'b1;
                cnt_q <= 4'h0;
            end
        end
    end
endmodule : flic_core_model

// ---- bench/four_level_interrupt_controller_bench.sv ----
`timescale 1ns/1ps

module four_level_interrupt_controller_bench;
    import flic_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic t0 = 1'b0;
    logic pin0 = 1'b1;
    logic t1 = 1'b0;
    logic we = 1'b0;
    logic [7:0] wd = 8'h00;
    flic_src_flags_t flags = '0;
    flic_cfg_t cfg = '0;
    logic last, blk, reti, ack, req;
    logic [15:0] addr;
    logic [7:0] timer_control_reg;
    logic [13:0] pend;
    logic [3:0] lvls;
    logic [15:0] vecs[$];
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    flic_ctrl i_flic_ctrl (.clock_i(clock_i), .rstn_i(rstn_i), .ext_pin0_input_i(pin0),
        .ext_pin1_input_i(1'b1), .timer0_overflow_i(t0), .timer1_overflow_i(t1), .src_flags_i(flags),
        .cfg_i(cfg), .timer_control_reg_we_i(we), .timer_control_reg_wdata_i(wd), .insn_last_i(last), .insn_block_i(blk),
        .reti_i(reti), .vector_ack_i(ack), .vector_req_o(req), .vector_addr_o(addr),
        .timer_control_reg_o(timer_control_reg), .active_levels_o(lvls), .pending_o(pend));
    flic_core_model i_flic_core_model (.clock_i(clock_i), .rstn_i(rstn_i), .vector_req_i(req),
        .vector_ack_o(ack), .insn_last_o(last), .insn_block_o(blk), .reti_o(reti));

    initial begin
        forever #50 clock_i = ~clock_i;
    end

    // --------------------------------------------------------------
    // Checking and closing
    // --------------------------------------------------------------
    always @(posedge clock_i) begin
        if (ack === 1'b1 && req === 1'b1)
            vecs.push_back(addr);
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic expect_vec(input logic [15:0] exp);
        int n = 0;
        while (vecs.size() == 0 && n < 60) begin
            @(posedge clock_i);
            n++;
        end
        check("vector", exp, (vecs.size() != 0) ? vecs.pop_front() : 16'hxxxx);
    endtask : expect_vec

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // Tests should end well inside a few hundred cycles.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        cfg.primary_enable_reg <= 8'h02;
        t0 <= 1'b1;
        @(posedge clock_i) t0 <= 1'b0;
        repeat (10) @(posedge clock_i);
        check("queued", 16'h0000, 16'(vecs.size()));
        check("timer_control_reg", 16'h0020, {8'h00, timer_control_reg});
        cfg.primary_enable_reg <= 8'h82;
        expect_vec(16'h000b);
        repeat (4) @(posedge clock_i);
        check("timer_control_reg", 16'h0000, {8'h00, timer_control_reg});
        $display("test global enable done");
        cfg.primary_enable_reg <= 8'h8a;
        t0 <= 1'b1;
        t1 <= 1'b1;
        @(posedge clock_i) t0 <= 1'b0;
        t1 <= 1'b0;
        expect_vec(16'h000b);
        expect_vec(16'h001b);
        $display("test polling order done");
        cfg.extended_enable_reg <= 8'h04;
        cfg.ext_priority_high_reg <= 8'h04;
        cfg.ext_priority_low_reg <= 8'h04;
        flags.array_base_overflow <= 1'b1;
        t0 <= 1'b1;
        @(posedge clock_i) t0 <= 1'b0;
        expect_vec(16'h004b);
        flags.array_base_overflow <= 1'b0;
        expect_vec(16'h000b);
        $display("test priority level done");
        cfg.ext_pin0_type <= 1'b1;
        cfg.primary_enable_reg <= 8'h81;
        we <= 1'b1;
        wd <= 8'h02;
        @(posedge clock_i) we <= 1'b0;
        expect_vec(16'h0003);
        repeat (4) @(posedge clock_i);
        check("timer_control_reg", 16'h0000, {8'h00, timer_control_reg});
        $display("test software edge flag done");
        cfg.primary_enable_reg <= 8'h90;
        flags.serial_rx_done <= 1'b1;
        expect_vec(16'h0023);
        repeat (8) @(posedge clock_i);
        check("pending", 16'h0010, {2'b00, pend});
        flags.serial_rx_done <= 1'b0;
        repeat (20) @(posedge clock_i);
        vecs.delete();
        $display("test serial flag kept done");
        cfg.ext_pin0_type <= 1'b0;
        cfg.primary_enable_reg <= 8'h81;
        pin0 <= 1'b0;
        expect_vec(16'h0003);
        repeat (2) @(posedge clock_i);
        check("levels", 16'h0001, {12'h000, lvls});
        repeat (2) @(posedge clock_i);
        check("timer_control_reg", 16'h0002, {8'h00, timer_control_reg});
        pin0 <= 1'b1;
        repeat (20) @(posedge clock_i);
        check("timer_control_reg", 16'h0000, {8'h00, timer_control_reg});
        vecs.delete();
        $display("test level pin done");
        end_sim();
    end
endmodule : four_level_interrupt_controller_bench
